// ### lfs_supervisor.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

module lfs_deglitch
	import lfs_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             clr,
	input  wire logic             run,
	input  wire logic             restart,
	input  wire logic [CNT_W-1:0] limit,
	output logic      [CNT_W-1:0] cnt,
	output logic                  hit
);
	logic [CNT_W-1:0] cnt_ff;

	assign hit = run && !restart && (cnt_ff == limit - CNT_W'(1));
	assign cnt = cnt_ff;

	always_ff @(posedge aclk) begin
		if (clr || !run || restart || hit) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end
endmodule

module lfs_supervisor
	import lfs_pkg::*;
#(
	parameter logic [CNT_W-1:0] ENABLE_CYCLES   = ENABLE_OUT_CYC,
	parameter logic [CNT_W-1:0] PWM_RISE_CYCLES = PWM_RISE_CYC,
	parameter logic [CNT_W-1:0] PWM_FALL_CYCLES = PWM_FALL_CYC,
	parameter logic [CNT_W-1:0] OPEN_CYCLES     = OPEN_DEG_CYC,
	parameter logic [CNT_W-1:0] GSHORT_CYCLES   = GSHORT_DEG_CYC,
	parameter logic [CNT_W-1:0] OVERTEMP_CYCLES = OVERTEMP_CYC,
	parameter logic [CNT_W-1:0] RECOVER_CYCLES  = RECOVER_CYC
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  enable_in,
	input  wire logic                  pwm_in,
	input  wire lfs_pkg::lfs_sense_type sense,
	input  wire logic                  fault_bus_in,
	output logic                       fault_bus_out,
	output logic                       fault_bus_oe,
	output logic                       fault_pullup_on,
	output logic                       drive_on,
	output logic                       retry_on,
	output logic                       sleep_on,
	input  wire logic [3:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [3:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	import lfs_pkg::*;

	logic             hold;
	logic             started_ff, pwm_dly_ff, armed_ff;
	logic             open_ff, gshort_ff, overtemp_ff;
	logic             drive_ff, retry_ff, sleep_ff, bus_oe_ff, pullup_ff, bus_out_ff;
	logic             ctrl_open_ff;
	logic [3:0]       event_ff;
	logic             bus_low_ff;
	logic             start_hit, pwm_hit, open_hit, gshort_hit, ot_hit;
	logic             open_rec_hit, gshort_rec_hit, ot_rec_hit;
	logic [CNT_W-1:0] start_cnt, open_cnt, unused_cnt0, unused_cnt1, unused_cnt2, unused_cnt3, unused_cnt4, unused_cnt5;
	logic             any_fault, pwm_diag;
	lfs_status_type   status;

	assign hold      = !aresetn || !sense.supply_ok || !enable_in;
	assign any_fault = open_ff || gshort_ff || overtemp_ff;
	assign pwm_diag  = started_ff && pwm_in;

	// startup delay from enable rise to first output
	lfs_deglitch u_start (.aclk(aclk), .clr(hold), .run(!started_ff), .restart(1'b0),
		.limit(ENABLE_CYCLES), .cnt(start_cnt), .hit(start_hit));
	always_ff @(posedge aclk) begin
		if (hold) begin
			started_ff <= 1'b0;
		end else if (start_hit) begin
			started_ff <= 1'b1;
		end
	end

	// pwm must stay at its new level for the whole delay; shorter pulses are swallowed
	lfs_deglitch u_pwm (.aclk(aclk), .clr(hold), .run(pwm_in != pwm_dly_ff), .restart(1'b0),
		.limit(pwm_in ? PWM_RISE_CYCLES : PWM_FALL_CYCLES), .cnt(unused_cnt0), .hit(pwm_hit));
	always_ff @(posedge aclk) begin
		if (hold) begin
			pwm_dly_ff <= 1'b0;
		end else if (pwm_hit) begin
			pwm_dly_ff <= pwm_in;
		end
	end

	// hysteresis between the two gate thresholds
	always_ff @(posedge aclk) begin
		if (hold) begin
			armed_ff <= 1'b0;
		end else if (sense.open_check_lo || !ctrl_open_ff) begin
			armed_ff <= 1'b0;
		end else if (sense.open_check_hi) begin
			armed_ff <= 1'b1;
		end
	end

	// between thresholds the open timer keeps counting
	lfs_deglitch u_open (.aclk(aclk), .clr(hold || open_ff),
		.run(pwm_diag && armed_ff && (sense.drop_below_open || open_cnt != '0)),
		.restart(sense.drop_above_open),
		.limit(OPEN_CYCLES), .cnt(open_cnt), .hit(open_hit));
	lfs_deglitch u_open_rec (.aclk(aclk), .clr(hold || !open_ff), .run(sense.drop_above_open),
		.restart(1'b0), .limit(RECOVER_CYCLES), .cnt(unused_cnt1), .hit(open_rec_hit));
	always_ff @(posedge aclk) begin
		// a gate dropping below its low threshold also beats a timer expiring on the same edge
		if (hold || !armed_ff || sense.open_check_lo) begin
			open_ff <= 1'b0;
		end else if (open_hit) begin
			open_ff <= 1'b1;
		end else if (open_rec_hit) begin
			open_ff <= 1'b0;
		end
	end

	lfs_deglitch u_gshort (.aclk(aclk), .clr(hold || gshort_ff),
		.run(drive_ff && (sense.out_below_gshort || unused_cnt2 != '0)),
		.restart(sense.out_above_gshort),
		.limit(GSHORT_CYCLES), .cnt(unused_cnt2), .hit(gshort_hit));
	lfs_deglitch u_gshort_rec (.aclk(aclk), .clr(hold || !gshort_ff), .run(sense.out_above_gshort),
		.restart(1'b0), .limit(RECOVER_CYCLES), .cnt(unused_cnt3), .hit(gshort_rec_hit));
	always_ff @(posedge aclk) begin
		if (hold) begin
			gshort_ff <= 1'b0;
		end else if (gshort_hit) begin
			gshort_ff <= 1'b1;
		end else if (gshort_rec_hit) begin
			gshort_ff <= 1'b0;
		end
	end

	lfs_deglitch u_ot (.aclk(aclk), .clr(hold || overtemp_ff), .run(sense.overtemp), .restart(1'b0),
		.limit(OVERTEMP_CYCLES), .cnt(unused_cnt4), .hit(ot_hit));
	lfs_deglitch u_ot_rec (.aclk(aclk), .clr(hold || !overtemp_ff), .run(sense.overtemp_clear),
		.restart(1'b0), .limit(RECOVER_CYCLES), .cnt(unused_cnt5), .hit(ot_rec_hit));
	always_ff @(posedge aclk) begin
		if (hold) begin
			overtemp_ff <= 1'b0;
		end else if (ot_hit) begin
			overtemp_ff <= 1'b1;
		end else if (ot_rec_hit) begin
			overtemp_ff <= 1'b0;
		end
	end

	// bus_low is sensed after the block's own pulldown, so a local fault also stops it
	always_ff @(posedge aclk) begin
		if (hold) begin
			drive_ff   <= 1'b0;
			retry_ff   <= 1'b0;
			bus_oe_ff  <= 1'b0;
			pullup_ff  <= 1'b0;
			bus_low_ff <= 1'b0;
		end else begin
			drive_ff   <= started_ff && pwm_dly_ff && !gshort_ff && !overtemp_ff && fault_bus_in;
			retry_ff   <= !overtemp_ff && (gshort_ff || (open_ff && !pwm_dly_ff));
			bus_oe_ff  <= any_fault;
			pullup_ff  <= !any_fault;
			bus_low_ff <= !fault_bus_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_ff   <= 1'b1;
			bus_out_ff <= 1'b0;
		end else begin
			sleep_ff   <= !enable_in;
			bus_out_ff <= 1'b0;
		end
	end

	assign drive_on        = drive_ff;
	assign retry_on        = retry_ff;
	assign sleep_on        = sleep_ff;
	assign fault_bus_oe    = bus_oe_ff;
	assign fault_bus_out   = bus_out_ff;
	assign fault_pullup_on = pullup_ff;

	assign status = '{open_armed: armed_ff, started: started_ff, retry_on: retry_ff, drive_on: drive_ff,
		bus_low: bus_low_ff, overtemp: overtemp_ff, gshort: gshort_ff, open: open_ff};

	// ---- AXI4-Lite slave ----
	logic        aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [3:0]  awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic        wlane0_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        do_write, ev_clr;
	logic [3:0]  ev_set;

	assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
	assign ev_clr   = do_write && wlane0_ff && awaddr_ff == ADDR_EVENT;
	assign ev_set   = {!bus_low_ff && !fault_bus_in && !hold, ot_hit, gshort_hit, open_hit};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wlane0_ff  <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_got_ff  <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end else if (do_write) begin
				aw_got_ff  <= 1'b0;
			end else if (!aw_got_ff && !bvalid_ff) begin
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_got_ff  <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wlane0_ff <= s_axi_wstrb[0];
				wready_ff <= 1'b0;
			end else if (do_write) begin
				w_got_ff  <= 1'b0;
			end else if (!w_got_ff && !bvalid_ff) begin
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_EVENT || awaddr_ff == ADDR_STATUS)
				? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_open_ff <= CTRL_RESET;
		end else if (do_write && wlane0_ff && awaddr_ff == ADDR_CTRL) begin
			ctrl_open_ff <= wdata_ff[CTRL_OPEN_ALLOW];
		end
	end

	// set beats clear so an event landing on the clearing write is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_ff <= '0;
		end else begin
			event_ff <= (event_ff & ~(ev_clr ? wdata_ff[3:0] : 4'h0)) | ev_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL:   rdata_ff <= {31'h0, ctrl_open_ff};
				ADDR_STATUS: rdata_ff <= {24'h0, status};
				ADDR_EVENT:  rdata_ff <= {28'h0, event_ff};
				default: begin
					rdata_ff <= '0;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_por_hold: assert property (!sense.supply_ok |=> !drive_ff && !retry_ff && !bus_oe_ff)
		else $error("output active below power-on threshold");
	a_sleep_off: assert property (!enable_in |=> !drive_ff && !retry_ff && !started_ff)
		else $error("output active while asleep");
	a_startup_delay: assert property ($rose(started_ff) |-> $past(start_cnt) == ENABLE_CYCLES - CNT_W'(1))
		else $error("startup delay wrong");
	a_pwm_gate: assert property (drive_ff |-> $past(pwm_dly_ff) && $past(started_ff))
		else $error("output on without pwm");
	a_diag_suspend: assert property (!pwm_in |=> open_cnt == '0)
		else $error("open timer ran with pwm low");
	a_gate_disarm: assert property (sense.open_check_lo |=> !armed_ff && !open_ff)
		else $error("open check armed below low threshold");
	a_open_restart: assert property (sense.drop_above_open |=> open_cnt == '0)
		else $error("open timer not restarted");
	a_fault_pull: assert property (any_fault && !hold |=> bus_oe_ff && !pullup_ff)
		else $error("fault not driven onto bus");
	a_bus_shut: assert property (!fault_bus_in |=> !drive_ff)
		else $error("output on with fault bus low");
	a_gshort_retry: assert property (gshort_ff && !overtemp_ff && !hold |=> retry_ff && !drive_ff)
		else $error("ground short not in retry");
	a_ot_off: assert property (overtemp_ff |=> !drive_ff)
		else $error("output on during overtemperature");
	// open fault with pwm low must fall back to the small retry current, never the main drive
	a_open_retry: assert property (open_ff && !gshort_ff && !overtemp_ff && !pwm_dly_ff && !hold |=> retry_ff && !drive_ff)
		else $error("open fault not retrying with pwm low");
	// recovery waits for a clean condition so a flickering string does not toggle the bus
	a_open_recover: assert property (open_ff && open_rec_hit && !hold |=> !open_ff)
		else $error("open fault kept after recovery");
	a_ot_recover: assert property (overtemp_ff && ot_rec_hit && !hold |=> !overtemp_ff)
		else $error("overtemperature kept after cooling");
endmodule

// ### lfs_pkg.sv
package lfs_pkg;
	localparam int CNT_W          = 16;
	localparam int CLK_MHZ        = 125;
	// times in microseconds as specified; cycle counts derive from the clock rate
	localparam int PWM_RISE_US    = 17;
	localparam int PWM_FALL_US    = 21;
	localparam int OVERTEMP_DEG_US = 60;
	localparam int ENABLE_OUT_US  = 100;
	localparam int OPEN_DEG_US    = 125;
	localparam int GSHORT_DEG_US  = 125;
	localparam int RECOVER_DEG_US = 16;
	localparam logic [CNT_W-1:0] PWM_RISE_CYC    = CNT_W'(PWM_RISE_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] PWM_FALL_CYC    = CNT_W'(PWM_FALL_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OVERTEMP_CYC    = CNT_W'(OVERTEMP_DEG_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] ENABLE_OUT_CYC  = CNT_W'(ENABLE_OUT_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] OPEN_DEG_CYC    = CNT_W'(OPEN_DEG_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] GSHORT_DEG_CYC  = CNT_W'(GSHORT_DEG_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] RECOVER_CYC     = CNT_W'(RECOVER_DEG_US * CLK_MHZ);

	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_EVENT  = 4'h8;
	localparam int          CTRL_OPEN_ALLOW = 0;
	localparam logic        CTRL_RESET  = 1'b1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// comparator and pin levels, all synchronous to aclk
	typedef struct packed {
		logic supply_ok;       // supply above rising power-on threshold
		logic open_check_hi;   // open_check_gate above high threshold
		logic open_check_lo;   // open_check_gate below low threshold
		logic drop_below_open; // in-to-out drop under lower open threshold
		logic drop_above_open; // in-to-out drop over upper open threshold
		logic out_below_gshort;
		logic out_above_gshort;
		logic overtemp;        // junction above thermal_shutdown threshold
		logic overtemp_clear;  // junction below threshold minus hysteresis
	} lfs_sense_type;

	typedef struct packed {
		logic open_armed;
		logic started;
		logic retry_on;
		logic drive_on;
		logic bus_low;
		logic overtemp;
		logic gshort;
		logic open;
	} lfs_status_type;
endpackage

// ### lfs_led_partner.sv
`timescale 1ns/1ps

// LED string, peer drivers and bus resistors seen from the supervisor pins
module lfs_led_partner
	import lfs_pkg::*;
#(
	parameter int PEERS = 3
) (
	input  wire logic           aclk,
	input  wire logic           supply_ok,
	input  wire logic           gate,
	input  wire logic           open_led,
	input  wire logic           short_gnd,
	input  wire logic           hot,
	input  wire logic           peer_pull,
	input  wire logic           strong_up,
	input  wire logic           fault_bus_oe,
	input  wire logic           fault_bus_out,
	input  wire logic           fault_pullup_on,
	output lfs_pkg::lfs_sense_type sense,
	output logic                fault_bus_in
);
	logic float_ff;

	initial float_ff = 1'b0;
	// an undriven bus wanders, so it never shows a stable level
	always @(posedge aclk) begin
		float_ff <= ~float_ff;
	end

	assign sense = {supply_ok, gate, ~gate, open_led, ~open_led, short_gnd, ~short_gnd, hot, ~hot};
	// a strong external pullup beats the device pulldown, a peer pulldown beats all
	assign fault_bus_in = peer_pull ? 1'b0 : strong_up ? 1'b1 : fault_bus_oe ? fault_bus_out :
		fault_pullup_on ? 1'b1 : float_ff;
endmodule

// ### tb_led_driver_fault_supervisor.sv
`timescale 1ns/1ps

module tb_led_driver_fault_supervisor;
	import lfs_pkg::*;
	localparam int EN = 8, PR = 4, PF = 6, OP = 12, GS = 10, OT = 9, RC = 5;
	logic          aclk, aresetn, enable_in, pwm_in, supply_ok, gate, open_led, short_gnd, hot, peer_pull, strong_up;
	lfs_sense_type sense;
	logic          fault_bus_in, fault_bus_out, fault_bus_oe, fault_pullup_on, drive_on, retry_on, sleep_on;
	logic [3:0]    awaddr, araddr, wstrb;
	logic [31:0]   wdata, rdata, rd;
	logic [1:0]    bresp, rresp;
	logic          awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int            miscompares, checks_done;

	lfs_supervisor #(.ENABLE_CYCLES(CNT_W'(EN)), .PWM_RISE_CYCLES(CNT_W'(PR)), .PWM_FALL_CYCLES(CNT_W'(PF)),
		.OPEN_CYCLES(CNT_W'(OP)), .GSHORT_CYCLES(CNT_W'(GS)), .OVERTEMP_CYCLES(CNT_W'(OT)),
		.RECOVER_CYCLES(CNT_W'(RC))) lfs_supervisor_inst (.aclk(aclk), .aresetn(aresetn), .enable_in(enable_in),
		.pwm_in(pwm_in), .sense(sense), .fault_bus_in(fault_bus_in), .fault_bus_out(fault_bus_out),
		.fault_bus_oe(fault_bus_oe), .fault_pullup_on(fault_pullup_on), .drive_on(drive_on), .retry_on(retry_on),
		.sleep_on(sleep_on), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	lfs_led_partner lfs_led_partner_inst (.aclk(aclk), .supply_ok(supply_ok), .gate(gate), .open_led(open_led),
		.short_gnd(short_gnd), .hot(hot), .peer_pull(peer_pull), .strong_up(strong_up),
		.fault_bus_oe(fault_bus_oe), .fault_bus_out(fault_bus_out), .fault_pullup_on(fault_pullup_on),
		.sense(sense), .fault_bus_in(fault_bus_in));

	always #4 aclk = ~aclk;

	function automatic logic sig(input int s);
		case (s)
			0: sig = drive_on;
			1: sig = retry_on;
			2: sig = fault_bus_oe;
			3: sig = sleep_on;
			default: sig = fault_pullup_on;
		endcase
	endfunction

	task automatic summarize();
		if (miscompares == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic lim(input int c);
		if (c >= 50) begin
			miscompares++;
			$display("[FAIL] axi handshake expected done seen timeout");
			summarize();
		end
	endtask

	// waits for a level; too early or never both count as a mismatch
	task automatic wt(input int s, input logic v, input int lo, input int hi, input string n);
		int c;
		c = 0;
		#1;
		while (sig(s) !== v && c <= hi) begin
			@(posedge aclk);
			#1;
			c++;
		end
		checks_done++;
		if (sig(s) !== v) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", n, v, sig(s));
			summarize();
		end else if (c < lo) begin
			miscompares++;
			$display("[FAIL] %s expected delay %0d seen %0d", n, lo, c);
		end
	endtask

	task automatic hold(input int s, input logic v, input int n, input string nm);
		int i;
		logic bad;
		bad = 1'b0;
		#1;
		for (i = 0; i < n; i++) begin
			if (sig(s) !== v) bad = 1'b1;
			@(posedge aclk);
			#1;
		end
		chk(nm, 32'(v), 32'(v ^ bad));
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int c;
		logic aw, w;
		c = 0;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w) && c < 50) begin
			@(posedge aclk);
			c++;
			if (awready && awvalid) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && wvalid) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			c++;
		end while (!bvalid && c < 50);
		bready <= 1'b0;
		lim(c);
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axr(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		int c;
		c = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			c++;
		end while (!arready && c < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			c++;
		end while (!rvalid && c < 50);
		rready <= 1'b0;
		d = rdata;
		lim(c);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic t_regs();
		chk("sleep_on", 1, sleep_on);
		chk("drive_on", 0, drive_on);
		axr(ADDR_CTRL, RESP_OKAY, rd);
		chk("ctrl reset", 32'h1, rd);
		axr(4'hC, RESP_SLVERR, rd);
		chk("unmapped read", 32'h0, rd);
		axw(4'hC, 32'hFFFFFFFF, RESP_SLVERR);
		axr(ADDR_CTRL, RESP_OKAY, rd);
		chk("ctrl kept", 32'h1, rd);
	endtask

	task automatic t_start();
		@(posedge aclk);
		enable_in <= 1'b1;
		pwm_in <= 1'b1;
		gate <= 1'b1;
		hold(0, 0, 40, "drive without supply");
		@(posedge aclk);
		supply_ok <= 1'b1;
		wt(0, 1, EN, EN + PR + 4, "startup drive");
		wt(4, 1, 0, 2, "pullup idle");
	endtask

	task automatic t_pwm();
		@(posedge aclk);
		pwm_in <= 1'b0;
		wt(0, 0, PF, PF + 3, "pwm fall");
		@(posedge aclk);
		pwm_in <= 1'b1;
		@(posedge aclk);
		pwm_in <= 1'b0;
		hold(0, 0, PR + 4, "pwm glitch");
		@(posedge aclk);
		pwm_in <= 1'b1;
		wt(0, 1, PR, PR + 3, "pwm rise");
	endtask

	task automatic t_open();
		@(posedge aclk);
		pwm_in <= 1'b0;
		open_led <= 1'b1;
		strong_up <= 1'b1;
		hold(2, 0, OP + 6, "open with pwm low");
		@(posedge aclk);
		gate <= 1'b0;
		pwm_in <= 1'b1;
		hold(2, 0, OP + 6, "open gate low");
		@(posedge aclk);
		gate <= 1'b1;
		repeat (OP - 4) @(posedge aclk);
		open_led <= 1'b0;
		@(posedge aclk);
		open_led <= 1'b1;
		hold(2, 0, OP - 1, "open restart");
		wt(2, 1, 0, 6, "open set");
		chk("bus level", 0, fault_bus_out);
		wt(4, 0, 0, 2, "pullup off");
		wt(0, 1, 0, 3, "open drive kept");
		axr(ADDR_STATUS, RESP_OKAY, rd);
		chk("status open", 32'h1, 32'(rd[0]));
		@(posedge aclk);
		pwm_in <= 1'b0;
		wt(1, 1, 0, PF + 3, "open retry");
		@(posedge aclk);
		pwm_in <= 1'b1;
		open_led <= 1'b0;
		wt(2, 0, RC, RC + 4, "open clear");
		axr(ADDR_EVENT, RESP_OKAY, rd);
		chk("event open", 32'h1, 32'(rd[0]));
		axw(ADDR_EVENT, 32'h1, RESP_OKAY);
		axr(ADDR_EVENT, RESP_OKAY, rd);
		chk("event cleared", 32'h0, 32'(rd[0]));
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		@(posedge aclk);
		open_led <= 1'b1;
		hold(2, 0, OP + 6, "open not allowed");
		@(posedge aclk);
		open_led <= 1'b0;
		strong_up <= 1'b0;
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
	endtask

	task automatic t_gshort();
		wt(0, 1, 0, PR + 6, "drive before short");
		@(posedge aclk);
		short_gnd <= 1'b1;
		repeat (GS - 3) @(posedge aclk);
		short_gnd <= 1'b0;
		@(posedge aclk);
		short_gnd <= 1'b1;
		hold(2, 0, GS - 1, "short restart");
		wt(2, 1, 0, 6, "short set");
		wt(0, 0, 0, 3, "short drive off");
		wt(1, 1, 0, 3, "short retry");
		@(posedge aclk);
		pwm_in <= 1'b0;
		hold(1, 1, PF + 6, "short retry pwm low");
		@(posedge aclk);
		pwm_in <= 1'b1;
		short_gnd <= 1'b0;
		wt(2, 0, RC, RC + 4, "short clear");
		wt(0, 1, 0, PR + 6, "short resume");
	endtask

	task automatic t_hot();
		@(posedge aclk);
		hot <= 1'b1;
		wt(2, 1, OT, OT + 4, "hot set");
		wt(0, 0, 0, 3, "hot drive off");
		@(posedge aclk);
		hot <= 1'b0;
		wt(2, 0, RC, RC + 4, "hot clear");
		wt(0, 1, 0, PR + 6, "hot resume");
		axr(ADDR_EVENT, RESP_OKAY, rd);
		chk("event faults", 32'h6, rd & 32'h6);
	endtask

	task automatic t_peer();
		axw(ADDR_EVENT, 32'hF, RESP_OKAY);
		@(posedge aclk);
		peer_pull <= 1'b1;
		wt(0, 0, 0, 3, "peer drive off");
		chk("peer own pulldown", 0, fault_bus_oe);
		@(posedge aclk);
		peer_pull <= 1'b0;
		wt(0, 1, 0, PR + 6, "peer resume");
		axr(ADDR_EVENT, RESP_OKAY, rd);
		chk("event bus low", 32'h8, rd);
		@(posedge aclk);
		enable_in <= 1'b0;
		wt(3, 1, 0, 2, "sleep entry");
		wt(0, 0, 0, 2, "sleep drive");
	endtask

	initial begin
		{aclk, aresetn, enable_in, pwm_in, supply_ok, gate, open_led, short_gnd, hot, peer_pull, strong_up} = '0;
		{awaddr, araddr, wstrb, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		miscompares = 0;
		checks_done = 0;
		repeat (10) @(posedge aclk);
		chk("sleep in reset", 1, sleep_on);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_start();
		t_pwm();
		t_open();
		t_gshort();
		t_hot();
		t_peer();
		summarize();
	end
endmodule
